// [adc_serial_ctrl.v]
// Serial control word, conversion sequencing and framed result output of the dual converter
//
// Overview of operation
// - Control line sampled each falling clock after read strobe, 12 bits MSB first.
// - Word: channel, update, deep, light, auto sleep, ref off, dual read, action; resets zero.
// - Channel code picks pair zero, pseudo-differential pairs, or pair one differential.
// - Update code 01 applies feature bits; 00 and 11 keep them; 10 never sent.
// - Sleep bits enable power-down, ref off disables reference, dual read enables special read.
// - Action 001 arms DAC write, 011 arms DAC read, 101 resets; others nothing.
// - Feature settings take effect on the twelfth clock after read strobe.
// - Ten-bit reference level register, upper two bits ignored, resets to 3FF.
// - Output data valid from third falling clock after read strobe.
// - Results are 12-bit two's complement.
// - Stored result may be read repeatedly until a new conversion.
// - Mode pins pick manual or automatic channel, and two outputs or line A only.
// - One conversion takes 16 clock cycles.
// - Trigger rise holds sample at once; busy then stays high for whole conversion.
// - Manual modes latch channel from word at second clock cycle falling edge.
// - Mode I frame: two zeros, result MSB first, two zeros; A and B lines.
// - Mode II: line B released, both results on A over 32 clocks, early triggers ignored.
// - Mode II frame: zero, converter indicator, result, two zeros.
// - Mode III: pairs alternate; frame is pair indicator, zero, result, two zeros.
// - Mode IV: alternate, line A only; pair, converter indicator, result, two zeros.
// - Line B released after first conversion following switch to single output.
// - After armed DAC write, next word carries ten-bit level after two ignored bits.
// - Reset command holds the block, except the result buffer, held result, pushed entry and frame shift registers, in reset for about 500 ns.
// - Power-down entered at twelfth falling edge of the setting access.
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
`default_nettype none
module adc_serial_ctrl #(
  parameter DATA_W = 12
) (
  // Clock and reset
  input  wire              clk,
  input  wire              resetn,
  // Host serial pins
  input  wire              adc_clock,
  input  wire              sample_hold_trigger,
  input  wire              read_strobe,
  input  wire              chip_sel_n,
  input  wire              serial_in,
  // Mode pins
  input  wire              chan_auto_pin,
  input  wire              single_out_pin,
  // Converter results
  input  wire [DATA_W-1:0] conv_a_data,
  input  wire [DATA_W-1:0] conv_b_data,
  // Serial outputs
  output reg               out_line_a,
  output reg               out_line_a_oe_n,
  output reg               out_line_b,
  output reg               out_line_b_oe_n,
  // Conversion status
  output reg               busy,
  output reg               hold,
  output reg  [1:0]        chan_sel,
  output reg               pair_sel,
  // Feature controls
  output reg               deep_sleep,
  output reg               light_sleep,
  output reg               sleep_after_convert,
  output reg               ref_off,
  output reg               dual_read,
  output reg  [`REF_WIDTH-1:0] reference_level,
  output reg               device_reset
);

  localparam ENTRY_W = 2 * DATA_W + 1;
  localparam integer RST_CYC_I = `RESET_CYCLES;

  // Conversion states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CONV = 3'h2;
  localparam [2:0] ST_PUSH = 3'h4;

  // Frame of indicator pair, result and two trailing zeros
  function [15:0] frame16;
    input            ind_hi;
    input            ind_lo;
    input [DATA_W-1:0] data;
    begin
      frame16 = {ind_hi, ind_lo, data, 2'b00};
    end
  endfunction

  // ---------------------------------------------------------------
  // Edge detection of host pins
  // ---------------------------------------------------------------
  reg clk_q_reg;
  reg trig_q_reg;
  wire clk_rise = adc_clock & ~clk_q_reg;
  wire clk_fall = ~adc_clock & clk_q_reg;
  wire trig_rise = sample_hold_trigger & ~trig_q_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_q_reg  <= 1'b0;
      trig_q_reg <= 1'b0;
    end else begin
      clk_q_reg  <= adc_clock;
      trig_q_reg <= sample_hold_trigger;
    end
  end

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  reg               push_valid_reg;
  reg [ENTRY_W-1:0] push_data_reg;
  reg [ENTRY_W-1:0] held_reg;
  reg               frame_act_reg;
  wire              push_ready;
  wire              pop_valid;
  wire [ENTRY_W-1:0] pop_data;
  wire              pop_ready = ~frame_act_reg;

  result_buffer #(
    .WIDTH (ENTRY_W),
    .DEPTH (2)
  ) u_result_buffer (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push_valid_reg),
    .in_data   (push_data_reg),
    .in_ready  (push_ready),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [2:0]  state_reg;
  reg [4:0]  conv_cnt_reg;
  reg [5:0]  gap_cnt_reg;
  reg [6:0]  rst_cnt_reg;
  reg [10:0] sin_shift_reg;
  reg [5:0]  rd_cnt_reg;
  reg [5:0]  flen_reg;
  reg [31:0] sh_a_reg;
  reg [15:0] sh_b_reg;
  reg [1:0]  ctrl_chan_reg;
  reg        dac_wr_arm_reg;
  reg        dac_rd_arm_reg;
  reg        b_off_reg;

  wire        soft_rst = (rst_cnt_reg != 7'h00);
  wire        asleep = deep_sleep | light_sleep;
  wire [11:0] word = {sin_shift_reg, serial_in};
  wire [2:0]  act = word[`CW_ACT_HI:`CW_ACT_LO];
  wire [5:0]  rd_next = rd_cnt_reg + 6'h01;
  wire        strobe_ok = ~frame_act_reg | (rd_cnt_reg >= `CW_WIDTH);
  wire        conv_ok = (state_reg == ST_IDLE) & ~asleep &
                        (~single_out_pin | (gap_cnt_reg >= `READ_CYCLE));

  // Frames for the current held result
  wire        held_pair = held_reg[ENTRY_W-1];
  wire [DATA_W-1:0] held_a = held_reg[2*DATA_W-1:DATA_W];
  wire [DATA_W-1:0] held_b = held_reg[DATA_W-1:0];
  wire        ind_pair = chan_auto_pin & held_pair;
  wire [15:0] frame_a = frame16(ind_pair, 1'b0, held_a);
  wire [15:0] frame_b = frame16(ind_pair, single_out_pin, held_b);
  wire [15:0] frame_dac = {4'h0, reference_level, 2'b00};

  // ---------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_IDLE;
      conv_cnt_reg   <= 5'h00;
      gap_cnt_reg    <= `READ_CYCLE;
      busy           <= 1'b0;
      hold           <= 1'b0;
      chan_sel       <= 2'h0;
      pair_sel       <= 1'b0;
      b_off_reg      <= 1'b0;
      push_valid_reg <= 1'b0;
      push_data_reg  <= {ENTRY_W{1'b0}};
    end else if (soft_rst) begin
      state_reg      <= ST_IDLE;
      conv_cnt_reg   <= 5'h00;
      gap_cnt_reg    <= `READ_CYCLE;
      busy           <= 1'b0;
      hold           <= 1'b0;
      chan_sel       <= 2'h0;
      pair_sel       <= 1'b0;
      b_off_reg      <= 1'b0;
      push_valid_reg <= 1'b0;
    end else begin
      if (clk_rise && gap_cnt_reg != `READ_CYCLE) begin
        gap_cnt_reg <= gap_cnt_reg + 6'h01;
      end
      case (state_reg)
        ST_IDLE: begin
          if (trig_rise && conv_ok) begin
            hold         <= 1'b1;
            conv_cnt_reg <= 5'h00;
            gap_cnt_reg  <= 6'h00;
            state_reg    <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (clk_rise) begin
            conv_cnt_reg <= conv_cnt_reg + 5'h01;
            busy         <= 1'b1;
          end
          if (clk_fall && conv_cnt_reg == `CHAN_LATCH_RISE && !chan_auto_pin) begin
            chan_sel <= ctrl_chan_reg;
          end
          if (clk_rise && conv_cnt_reg == `CONV_CLOCKS - 5'h01) begin
            busy           <= 1'b0;
            hold           <= 1'b0;
            push_valid_reg <= 1'b1;
            push_data_reg  <= {pair_sel, conv_a_data, conv_b_data};
            b_off_reg      <= single_out_pin;
            if (chan_auto_pin) begin
              pair_sel <= ~pair_sel;
              chan_sel <= pair_sel ? 2'h0 : 2'h3;
            end else begin
              pair_sel <= chan_sel[1];
            end
            state_reg <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (push_ready) begin
            push_valid_reg <= 1'b0;
            state_reg      <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control word, features and reference level
  // ---------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_reg         <= 7'h00;
      device_reset        <= 1'b0;
      sin_shift_reg       <= 11'h000;
      ctrl_chan_reg       <= 2'h0;
      deep_sleep          <= 1'b0;
      light_sleep         <= 1'b0;
      sleep_after_convert <= 1'b0;
      ref_off             <= 1'b0;
      dual_read           <= 1'b0;
      reference_level     <= `REF_RESET;
      dac_wr_arm_reg      <= 1'b0;
      dac_rd_arm_reg      <= 1'b0;
    end else if (soft_rst) begin
      rst_cnt_reg         <= rst_cnt_reg - 7'h01;
      device_reset        <= (rst_cnt_reg != 7'h01);
      sin_shift_reg       <= 11'h000;
      ctrl_chan_reg       <= 2'h0;
      deep_sleep          <= 1'b0;
      light_sleep         <= 1'b0;
      sleep_after_convert <= 1'b0;
      ref_off             <= 1'b0;
      dual_read           <= 1'b0;
      reference_level     <= `REF_RESET;
      dac_wr_arm_reg      <= 1'b0;
      dac_rd_arm_reg      <= 1'b0;
    end else if (clk_fall) begin
      if (read_strobe && strobe_ok) begin
        sin_shift_reg <= {10'h000, serial_in};
        if (dac_rd_arm_reg) begin
          dac_rd_arm_reg <= 1'b0;
        end
      end else if (frame_act_reg && rd_cnt_reg < `CW_WIDTH) begin
        sin_shift_reg <= word[10:0];
        if (rd_next == `CW_WIDTH) begin
          if (dac_wr_arm_reg) begin
            reference_level <= word[`REF_WIDTH-1:0];
            dac_wr_arm_reg  <= 1'b0;
          end else begin
            ctrl_chan_reg <= word[`CW_CHAN_HI:`CW_CHAN_LO];
            if (word[`CW_UPD_HI:`CW_UPD_LO] == `UPD_APPLY) begin
              deep_sleep          <= word[`CW_DEEP_SLEEP];
              light_sleep         <= word[`CW_LIGHT_SLEEP];
              sleep_after_convert <= word[`CW_AUTO_SLEEP];
              ref_off             <= word[`CW_REF_OFF];
              dual_read           <= word[`CW_DUAL_READ];
            end
            if (act == `ACT_DAC_WRITE) begin
              dac_wr_arm_reg <= 1'b1;
            end
            if (act == `ACT_DAC_READ) begin
              dac_rd_arm_reg <= 1'b1;
            end
            if (act == `ACT_RESET) begin
              rst_cnt_reg  <= RST_CYC_I[6:0];
              device_reset <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Output framing
  // ---------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_act_reg   <= 1'b0;
      rd_cnt_reg      <= 6'h00;
      flen_reg        <= `FRAME_SHORT;
      sh_a_reg        <= 32'h00000000;
      sh_b_reg        <= 16'h0000;
      held_reg        <= {ENTRY_W{1'b0}};
      out_line_a      <= 1'b0;
      out_line_b      <= 1'b0;
      out_line_a_oe_n <= 1'b1;
      out_line_b_oe_n <= 1'b1;
    end else begin
      out_line_a_oe_n <= chip_sel_n | soft_rst;
      out_line_b_oe_n <= chip_sel_n | soft_rst | b_off_reg;
      if (soft_rst) begin
        frame_act_reg <= 1'b0;
        rd_cnt_reg    <= 6'h00;
        out_line_a    <= 1'b0;
        out_line_b    <= 1'b0;
      end else begin
        if (pop_valid && pop_ready) begin
          held_reg <= pop_data;
        end
        if (clk_fall) begin
          if (read_strobe && strobe_ok) begin
            frame_act_reg <= 1'b1;
            rd_cnt_reg    <= 6'h01;
            out_line_a    <= 1'b0;
            out_line_b    <= 1'b0;
            sh_b_reg      <= frame16(ind_pair, 1'b0, held_b);
            if (dac_rd_arm_reg) begin
              sh_a_reg <= {frame_dac, 16'h0000};
              flen_reg <= `FRAME_SHORT;
            end else if (single_out_pin) begin
              sh_a_reg <= {frame_a, frame_b};
              flen_reg <= `FRAME_LONG;
            end else begin
              sh_a_reg <= {frame_a, 16'h0000};
              flen_reg <= `FRAME_SHORT;
            end
          end else if (frame_act_reg) begin
            rd_cnt_reg <= rd_next;
            if (rd_next >= `FIRST_OUT_EDGE &&
                rd_next < flen_reg + `FIRST_OUT_EDGE) begin
              out_line_a <= sh_a_reg[31];
              out_line_b <= sh_b_reg[15];
              sh_a_reg   <= {sh_a_reg[30:0], 1'b0};
              sh_b_reg   <= {sh_b_reg[14:0], 1'b0};
            end else begin
              out_line_a <= 1'b0;
              out_line_b <= 1'b0;
            end
            if (rd_next == flen_reg + `FIRST_OUT_EDGE) begin
              frame_act_reg <= 1'b0;
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// [adc_ctrl_map.vh]
// Field positions, codes, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Control word layout
`define CW_WIDTH        12
`define CW_CHAN_HI      11
`define CW_CHAN_LO      10
`define CW_UPD_HI       9
`define CW_UPD_LO       8
`define CW_DEEP_SLEEP   7
`define CW_LIGHT_SLEEP  6
`define CW_AUTO_SLEEP   5
`define CW_REF_OFF      4
`define CW_DUAL_READ    3
`define CW_ACT_HI       2
`define CW_ACT_LO       0
`define CW_RESET        12'h000

// Feature update and action codes
`define UPD_APPLY       2'h1
`define ACT_DAC_WRITE   3'h1
`define ACT_DAC_READ    3'h3
`define ACT_RESET       3'h5

// Reference level register
`define REF_WIDTH       10
`define REF_RESET       10'h3FF

// Serial framing
`define FRAME_SHORT     6'h10
`define FRAME_LONG      6'h20
`define FIRST_OUT_EDGE  6'h03
`define CHAN_LATCH_RISE 5'h02
`define CONV_CLOCKS     5'h10
`define READ_CYCLE      6'h20

// Reset command hold
`define CLK_PERIOD_NS   8
`define RESET_HOLD_NS   500
`define RESET_CYCLES    ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [result_buffer.v]
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module result_buffer #(
  parameter WIDTH = 25,
  parameter DEPTH = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0]       count_reg;
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[1:0]);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg  <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// [adc_serial_ctrl_assertions.sv]
// Concurrent checks on the ports of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_serial_ctrl_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Host pins
  input wire logic       adc_clock,
  input wire logic       sample_hold_trigger,
  input wire logic       chip_sel_n,
  input wire logic       single_out_pin,
  // Observed outputs
  input wire logic       out_line_a_oe_n,
  input wire logic       out_line_b_oe_n,
  input wire logic       busy,
  input wire logic       hold,
  input wire logic       deep_sleep,
  input wire logic       light_sleep,
  input wire logic       sleep_after_convert,
  input wire logic       ref_off,
  input wire logic       dual_read,
  input wire logic [9:0] reference_level,
  input wire logic       device_reset
);
  // ----------------------------------------
  // Edge finder and cycle counters
  // ----------------------------------------
  logic       adc_q;
  logic [4:0] rise_cnt;
  logic [6:0] rst_cnt;
  wire        adc_fall = adc_q & ~adc_clock;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adc_q    <= 1'b0;
      rise_cnt <= 5'h00;
      rst_cnt  <= 7'h00;
    end else begin
      adc_q    <= adc_clock;
      rise_cnt <= busy ? rise_cnt + {4'h0, adc_clock & ~adc_q} : 5'h00;
      rst_cnt  <= device_reset ? rst_cnt + 7'h01 : 7'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_trig_rise;
    !sample_hold_trigger ##1 sample_hold_trigger;
  endsequence
  sequence s_idle;
    !hold && !busy && !deep_sleep && !light_sleep && !single_out_pin && !device_reset;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_TRIG_HOLD: assert property (s_trig_rise ##0 s_idle |-> ##[1:2] hold)
    else $error("trigger rise not followed by hold");
  AST_BUSY_IN_HOLD: assert property (busy |-> hold)
    else $error("busy high without hold");
  AST_BUSY_LEN: assert property ($fell(busy) && !device_reset |-> rise_cnt == 5'h0F && !hold)
    else $error("conversion length wrong");
  AST_CS_OE: assert property (chip_sel_n |=> out_line_a_oe_n && out_line_b_oe_n)
    else $error("line driven while deselected");
  AST_B_RELEASE: assert property ($fell(busy) && single_out_pin |-> ##[0:2] out_line_b_oe_n)
    else $error("line b not released");
  AST_RST_LEN: assert property ($fell(device_reset) |-> rst_cnt == 7'h3F)
    else $error("reset command hold length wrong");
  AST_RST_STATE: assert property (device_reset && $past(device_reset) |->
    out_line_a_oe_n && out_line_b_oe_n && reference_level == 10'h3FF && !busy)
    else $error("state not reset during command reset");
  AST_FEAT_AT_FALL: assert property (
    !$stable({deep_sleep, light_sleep, sleep_after_convert, ref_off, dual_read}) |->
    $past(adc_fall) || $past(adc_fall, 2) || $past(device_reset))
    else $error("feature change away from a clock fall");
  AST_REF_RESET: assert property ($rose(resetn) |-> reference_level == 10'h3FF)
    else $error("reference level reset value wrong");
endmodule
bind adc_serial_ctrl adc_serial_ctrl_assertions chk_u (.clk, .resetn, .adc_clock, .sample_hold_trigger, .chip_sel_n,
  .single_out_pin, .out_line_a_oe_n, .out_line_b_oe_n, .busy, .hold, .deep_sleep, .light_sleep,
  .sleep_after_convert, .ref_off, .dual_read, .reference_level, .device_reset);
`default_nettype wire

// [host_model.sv]
// Behavioural host that drives the control pins and captures serial frames
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk,
  // Host pins
  output var  logic        adc_clock,
  output var  logic        sample_hold_trigger,
  output var  logic        read_strobe,
  output var  logic        chip_sel_n,
  output var  logic        serial_in,
  // Board level serial lines
  input  wire logic        line_a,
  input  wire logic        line_b,
  // Captured frames
  output var  logic [31:0] frame_a,
  output var  logic [31:0] frame_b,
  output var  logic        frame_done
);
  initial begin
    adc_clock           = 1'b0;
    sample_hold_trigger = 1'b0;
    read_strobe         = 1'b0;
    chip_sel_n          = 1'b1;
    serial_in           = 1'b0;
    frame_a             = 32'h0000_0000;
    frame_b             = 32'h0000_0000;
    frame_done          = 1'b0;
  end
  // ----------------------------------------
  // One access: 36 converter clocks, clock low afterwards
  // ----------------------------------------
  task automatic access(input logic [11:0] word, input logic trig, input logic rd, input logic cs);
    integer k;
    begin
      @(negedge clk);
      sample_hold_trigger = trig;
      read_strobe         = rd;
      chip_sel_n          = ~cs;
      for (k = 1; k <= 36; k = k + 1) begin
        if (k == 2) begin
          sample_hold_trigger = 1'b0;
          read_strobe         = 1'b0;
        end
        serial_in = (k <= 12) ? word[12-k] : ~serial_in;
        adc_clock = 1'b1;
        repeat (2) @(negedge clk);
        if (k >= 4 && k <= 35) begin
          frame_a = {frame_a[30:0], line_a};
          frame_b = {frame_b[30:0], line_b};
        end
        adc_clock = 1'b0;
        repeat (2) @(negedge clk);
      end
      chip_sel_n = 1'b1;
      frame_done = cs;
      @(negedge clk);
      frame_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [dual_adc_serial_control_bench.sv]
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_control_bench;
  logic        clk, resetn, chan_auto_pin, single_out_pin;
  logic [11:0] conv_a_data, conv_b_data, ra, rb;
  logic [9:0]  dac;
  logic [1:0]  cs0;
  logic [63:0] exp_q[$];
  logic [11:0] fw[5] = '{12'h138, 12'h300, 12'h000, 12'h1C0, 12'h100};
  logic [4:0]  fe[5] = '{5'h07, 5'h07, 5'h07, 5'h18, 5'h00};
  integer      n_mismatch, compares, seed, k;
  wire         adc_clock, sample_hold_trigger, read_strobe, chip_sel_n, serial_in;
  wire         out_line_a, out_line_a_oe_n, out_line_b, out_line_b_oe_n, busy, hold, pair_sel;
  wire         deep_sleep, light_sleep, sleep_after_convert, ref_off, dual_read, device_reset, frame_done;
  wire [1:0]   chan_sel;
  wire [9:0]   reference_level;
  wire [31:0]  frame_a, frame_b;
  wire         line_a = out_line_a_oe_n ? 1'bz : out_line_a;
  wire         line_b = out_line_b_oe_n ? 1'bz : out_line_b;
  adc_serial_ctrl dut_u (.clk, .resetn, .adc_clock, .sample_hold_trigger, .read_strobe, .chip_sel_n, .serial_in,
    .chan_auto_pin, .single_out_pin, .conv_a_data, .conv_b_data, .out_line_a, .out_line_a_oe_n, .out_line_b,
    .out_line_b_oe_n, .busy, .hold, .chan_sel, .pair_sel, .deep_sleep, .light_sleep, .sleep_after_convert,
    .ref_off, .dual_read, .reference_level, .device_reset);
  host_model host_u (.clk, .adc_clock, .sample_hold_trigger, .read_strobe, .chip_sel_n, .serial_in, .line_a,
    .line_b, .frame_a, .frame_b, .frame_done);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Compare, report and conversion tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task automatic conv_read(input logic [11:0] a, input logic [11:0] b, input logic single, input integer reads);
    integer i;
    begin
      conv_a_data    = a;
      conv_b_data    = b;
      single_out_pin = single;
      host_u.access(12'h000, 1'b1, 1'b0, 1'b0);
      for (i = 0; i < reads; i = i + 1) begin
        if (single)
          exp_q.push_back({2'b00, a, 4'b0001, b, 2'b00, {32{1'bz}}});
        else
          exp_q.push_back({2'b00, a, 18'h00000, 2'b00, b, 2'b00, 16'h0000});
        host_u.access(12'h000, 1'b0, 1'b1, 1'b1);
      end
    end
  endtask
  always @(posedge clk) begin
    if (frame_done === 1'b1 && exp_q.size() > 0)
      chk({frame_a, frame_b}, exp_q.pop_front());
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed           = 18;
    n_mismatch     = 0;
    compares       = 0;
    resetn         = 1'b0;
    chan_auto_pin  = 1'b0;
    single_out_pin = 1'b0;
    conv_a_data    = 12'h000;
    conv_b_data    = 12'h000;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk({out_line_a_oe_n, out_line_b_oe_n, reference_level}, {2'b11, 10'h3FF});
    chk({deep_sleep, light_sleep, sleep_after_convert, ref_off, dual_read}, 5'h00);
    for (k = 0; k < 5; k = k + 1) begin
      host_u.access(fw[k], 1'b0, 1'b1, 1'b0);
      chk({deep_sleep, light_sleep, sleep_after_convert, ref_off, dual_read}, fe[k]);
    end
    for (k = 0; k < 4; k = k + 1) begin
      host_u.access({k[1:0], 10'h000}, 1'b0, 1'b1, 1'b0);
      host_u.access(12'h000, 1'b1, 1'b0, 1'b0);
      chk(chan_sel, k[1:0]);
    end
    ra = 12'($random(seed));
    rb = 12'($random(seed));
    conv_read(ra, rb, 1'b0, 2);
    conv_read(12'h7FF, 12'h800, 1'b0, 1);
    conv_read(rb, ra, 1'b1, 1);
    conv_read(12'hFFF, 12'h000, 1'b0, 1);
    dac = 10'($random(seed));
    host_u.access(12'h101, 1'b0, 1'b1, 1'b0);
    host_u.access({2'b11, dac}, 1'b0, 1'b1, 1'b0);
    chk(reference_level, dac);
    host_u.access(12'h103, 1'b0, 1'b1, 1'b0);
    exp_q.push_back({4'h0, dac, 2'b00, 48'h0});
    host_u.access(12'h000, 1'b0, 1'b1, 1'b1);
    chan_auto_pin = 1'b1;
    host_u.access(12'h000, 1'b1, 1'b0, 1'b0);
    cs0 = chan_sel;
    host_u.access(12'h000, 1'b1, 1'b0, 1'b0);
    chk({cs0 ^ chan_sel, cs0[1] ^ cs0[0], pair_sel ^ chan_sel[0]}, 4'b1100);
    exp_q.push_back({cs0[1], 1'b0, 12'hFFF, 18'h00000, cs0[1], 1'b0, 12'h000, 18'h00000});
    host_u.access(12'h000, 1'b0, 1'b1, 1'b1);
    chan_auto_pin = 1'b0;
    host_u.access(12'h105, 1'b0, 1'b1, 1'b0);
    chk({device_reset, reference_level}, {1'b0, 10'h3FF});
    chk(64'(exp_q.size()), 64'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
